// >>> include/pcs_pkg.sv
// Purpose: constants for the configuration command and status words
// Assumes: configuration accesses are whole dwords with byte enables
// Notes: status word sits in the upper half of the dword at 04h
package pcs_pkg;
    // ========================================
    // offsets
    localparam logic [7:0] CMD_OFFSET = 8'h04;
    localparam logic [7:0] STS_OFFSET = 8'h06;
    localparam logic [7:0] CAP_PTR_OFFSET = 8'h34;
    // ========================================
    // command field positions
    localparam int CMD_IO_BIT = 0;
    localparam int CMD_MEM_BIT = 1;
    localparam logic [1:0] CMD_ENABLES_RESET = 2'h0;
    // ========================================
    // status field positions
    localparam int STS_WORD_LSB = 16;
    localparam int STS_PARITY_ERR_BIT = 15;
    localparam int STS_SYS_ERR_BIT = 14;
    localparam int STS_MASTER_ABORT_BIT = 13;
    localparam int STS_TARGET_ABORT_RX_BIT = 12;
    localparam int STS_TARGET_ABORT_TX_BIT = 11;
    localparam int STS_SEL_LO_BIT = 9;
    localparam int STS_MASTER_PARITY_BIT = 8;
    localparam int STS_FAST_B2B_BIT = 7;
    localparam int STS_HIGH_SPEED_BIT = 5;
    localparam int STS_CAP_LIST_BIT = 4;
    // ========================================
    // fixed status values, capability pointer and reset values
    localparam logic [1:0] SEL_TIMING_MEDIUM = 2'h1;
    localparam logic FAST_B2B_VALUE = 1'b0;
    localparam logic HIGH_SPEED_VALUE = 1'b0;
    localparam logic CAP_LIST_VALUE = 1'b1;
    localparam logic [7:0] CAP_PTR_VALUE = 8'h40;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [31:0] RDATA_RESET = 32'h00000000;
    localparam logic ACK_RESET = 1'b0;
endpackage

// >>> logic/pcs_config_regs.sv
// Purpose: command enables and read-only status word of a bus function
// Assumes: one clock, synchronous active-high reset, dword config accesses
// Notes: flags are sticky until reset; status ignores every write
//
// Operation
// - memory space enable set claims memory accesses, cleared ignores them
// - io space enable set claims io accesses, cleared ignores them
// - reset forces both space enables to zero
// - sixteen-bit status word records bus events, writes cannot change it
// - read-only speed bit: zero means 33 MHz only, one means 66 MHz
// - read-only bit shows whether offset 34h holds a capability pointer
// - with capability bit one, offset 34h returns pointer to first entry
// - with capability bit zero, no capability list exists
`timescale 1ns/1ps
module pcs_config_regs (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cfg_sel,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    input wire logic mem_hit,
    input wire logic io_hit,
    output logic mem_claim,
    output logic io_claim,
    input wire logic ev_parity_err,
    input wire logic ev_serr,
    input wire logic ev_master_abort,
    input wire logic ev_target_abort_rx,
    input wire logic ev_target_abort_tx,
    input wire logic ev_master_parity
);
    // ========================================
    // decode
    function automatic logic dword_is(input logic [7:0] a, input logic [7:0] off);
        dword_is = (a[7:2] == off[7:2]);
    endfunction

    logic memory_space_enable_reg;
    logic io_space_enable_reg;
    logic memory_space_enable_next;
    logic io_space_enable_next;
    logic [5:0] flags_reg;
    logic [5:0] flags_next;
    logic [31:0] cfg_rdata_next;
    logic [15:0] status_word;
    logic [15:0] command_word;
    logic [1:0] target_select_timing;
    logic capability_list_present;
    logic high_speed_bus_capable;
    logic cmd_write;
    logic hit_cmd;
    logic hit_cap;
    logic [5:0] events;
    logic [31:0] cfg_rdata_reg;
    logic cfg_ack_reg;
    logic cfg_ack_next;
    logic rd_req;
    logic rd_cmd;
    logic rd_cap;
    logic [7:0] cap_ptr_byte;
    logic [15:0] rdata_status;

    assign hit_cmd = dword_is(cfg_addr, pcs_pkg::CMD_OFFSET);
    assign hit_cap = dword_is(cfg_addr, pcs_pkg::CAP_PTR_OFFSET);
    assign cmd_write = cfg_sel & cfg_wr & hit_cmd & cfg_be[0];
    assign memory_space_enable_next = cmd_write ? cfg_wdata[pcs_pkg::CMD_MEM_BIT]
                                                : memory_space_enable_reg;
    assign io_space_enable_next = cmd_write ? cfg_wdata[pcs_pkg::CMD_IO_BIT]
                                            : io_space_enable_reg;

    // ========================================
    // space claim gating
    assign mem_claim = mem_hit & memory_space_enable_reg;
    assign io_claim = io_hit & io_space_enable_reg;

    // ========================================
    // status word, fixed fields and sticky flags
    assign target_select_timing = pcs_pkg::SEL_TIMING_MEDIUM;
    assign capability_list_present = pcs_pkg::CAP_LIST_VALUE;
    assign high_speed_bus_capable = pcs_pkg::HIGH_SPEED_VALUE;
    assign events = {ev_parity_err, ev_serr, ev_master_abort,
                     ev_target_abort_rx, ev_target_abort_tx, ev_master_parity};
    assign flags_next = flags_reg | events;
    assign command_word = {14'h0000, memory_space_enable_reg, io_space_enable_reg};
    assign status_word = {flags_reg[5:1], target_select_timing, flags_reg[0],
                          pcs_pkg::FAST_B2B_VALUE, 1'b0, high_speed_bus_capable,
                          capability_list_present, 4'h0};

    // ========================================
    // read path
    assign rd_req = cfg_sel & ~cfg_wr;
    assign rd_cmd = rd_req & hit_cmd;
    assign rd_cap = rd_req & hit_cap;
    assign cap_ptr_byte = capability_list_present ? pcs_pkg::CAP_PTR_VALUE
                                                  : 8'h00;
    assign cfg_rdata_next = rd_cmd ? {status_word, command_word}
                          : rd_cap ? {24'h000000, cap_ptr_byte}
                          : 32'h00000000;
    assign cfg_ack_next = cfg_sel;
    assign cfg_rdata = cfg_rdata_reg;
    assign cfg_ack = cfg_ack_reg;
    assign rdata_status = cfg_rdata[31:16];

    // ========================================
    // registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            {memory_space_enable_reg, io_space_enable_reg}
                <= pcs_pkg::CMD_ENABLES_RESET;
            flags_reg <= pcs_pkg::FLAGS_RESET;
            cfg_rdata_reg <= pcs_pkg::RDATA_RESET;
            cfg_ack_reg <= pcs_pkg::ACK_RESET;
        end
        else
        begin
            memory_space_enable_reg <= memory_space_enable_next;
            io_space_enable_reg <= io_space_enable_next;
            flags_reg <= flags_next;
            cfg_rdata_reg <= cfg_rdata_next;
            cfg_ack_reg <= cfg_ack_next;
        end
    end

    // ========================================
    // checks: command enables and claims
    a_mem_claim_gate: assert property (@(posedge mclk) disable iff (rst)
        cmd_write ##1 mem_hit |-> mem_claim == $past(cfg_wdata[pcs_pkg::CMD_MEM_BIT]))
        else $error("memory claim does not follow enable");
    a_io_claim_gate: assert property (@(posedge mclk) disable iff (rst)
        cmd_write && !cfg_wdata[pcs_pkg::CMD_IO_BIT] ##1 io_hit |-> !io_claim)
        else $error("io claimed after io enable cleared");
    a_io_enable_claim: assert property (@(posedge mclk) disable iff (rst)
        cmd_write && cfg_wdata[pcs_pkg::CMD_IO_BIT] ##1 io_hit |-> io_claim)
        else $error("io not claimed after io enable set");
    a_mem_enable_write: assert property (@(posedge mclk) disable iff (rst)
        cmd_write |=> memory_space_enable_reg == $past(cfg_wdata[pcs_pkg::CMD_MEM_BIT]))
        else $error("memory enable not written");
    a_io_enable_write: assert property (@(posedge mclk) disable iff (rst)
        cmd_write |=> io_space_enable_reg == $past(cfg_wdata[pcs_pkg::CMD_IO_BIT]))
        else $error("io enable not written");
    a_enables_hold: assert property (@(posedge mclk) disable iff (rst)
        !cmd_write |=> $stable(memory_space_enable_reg) && $stable(io_space_enable_reg))
        else $error("space enables changed without a command write");
    a_command_readback: assert property (@(posedge mclk) disable iff (rst)
        rd_cmd |=> cfg_rdata[pcs_pkg::CMD_MEM_BIT] == $past(memory_space_enable_reg)
                   && cfg_rdata[pcs_pkg::CMD_IO_BIT] == $past(io_space_enable_reg))
        else $error("command enables read back wrong");
    a_enables_reset: assert property (@(posedge mclk)
        rst |=> !memory_space_enable_reg && !io_space_enable_reg)
        else $error("space enables not cleared by reset");
    a_claims_reset: assert property (@(posedge mclk)
        rst |=> !mem_claim && !io_claim)
        else $error("space claimed right after reset");

    // ========================================
    // checks: status word
    a_status_write_ignored: assert property (@(posedge mclk) disable iff (rst)
        (cfg_sel && cfg_wr && events == 6'h00) |=> $stable(status_word))
        else $error("status word changed by a write");
    a_read_status: assert property (@(posedge mclk) disable iff (rst)
        rd_cmd |=> rdata_status == $past(status_word))
        else $error("status word reads wrong");
    a_write_no_data: assert property (@(posedge mclk) disable iff (rst)
        cfg_sel && cfg_wr |=> cfg_rdata == 32'h00000000)
        else $error("write returned read data");
    a_speed_bit_fixed: assert property (@(posedge mclk) disable iff (rst)
        rd_cmd |=> cfg_ack && rdata_status[pcs_pkg::STS_HIGH_SPEED_BIT] == 1'b0)
        else $error("speed bit reads wrong");
    a_cap_bit_set: assert property (@(posedge mclk) disable iff (rst)
        rd_cmd |=> rdata_status[pcs_pkg::STS_CAP_LIST_BIT] == pcs_pkg::CAP_LIST_VALUE)
        else $error("capability bit reads wrong");
    a_timing_medium: assert property (@(posedge mclk) disable iff (rst)
        rd_cmd |=> rdata_status[pcs_pkg::STS_SEL_LO_BIT +: 2] == 2'h1)
        else $error("target select timing not medium");
    a_flags_reset: assert property (@(posedge mclk)
        rst |=> flags_reg == pcs_pkg::FLAGS_RESET)
        else $error("status flags not cleared by reset");

    // ========================================
    // checks: event flags
    a_flag_sticky: assert property (@(posedge mclk) disable iff (rst)
        ev_serr |=> status_word[pcs_pkg::STS_SYS_ERR_BIT] [*3])
        else $error("system error flag not sticky");
    a_parity_flag: assert property (@(posedge mclk) disable iff (rst)
        ev_parity_err |=> status_word[pcs_pkg::STS_PARITY_ERR_BIT])
        else $error("parity error flag not set");
    a_master_abort_flag: assert property (@(posedge mclk) disable iff (rst)
        ev_master_abort |=> status_word[pcs_pkg::STS_MASTER_ABORT_BIT])
        else $error("master abort flag not set");
    a_abort_rx_flag: assert property (@(posedge mclk) disable iff (rst)
        ev_target_abort_rx |=> status_word[pcs_pkg::STS_TARGET_ABORT_RX_BIT])
        else $error("received target abort flag not set");
    a_abort_tx_flag: assert property (@(posedge mclk) disable iff (rst)
        ev_target_abort_tx |=> status_word[pcs_pkg::STS_TARGET_ABORT_TX_BIT])
        else $error("signaled target abort flag not set");
    a_master_parity_flag: assert property (@(posedge mclk) disable iff (rst)
        ev_master_parity |=> status_word[pcs_pkg::STS_MASTER_PARITY_BIT])
        else $error("master parity flag not set");

    // ========================================
    // checks: capability pointer
    a_cap_pointer: assert property (@(posedge mclk) disable iff (rst)
        rd_cap && capability_list_present
        |=> cfg_rdata[7:0] == pcs_pkg::CAP_PTR_VALUE && cfg_rdata[31:8] == 24'h000000)
        else $error("capability pointer reads wrong");
    a_no_list_no_ptr: assert property (@(posedge mclk) disable iff (rst)
        rd_cap |=> (cfg_rdata[7:0] != 8'h00) == $past(capability_list_present))
        else $error("pointer presence does not match capability bit");
    a_cap_ptr_aligned: assert property (@(posedge mclk) disable iff (rst)
        rd_cap && capability_list_present |=> cfg_rdata[1:0] == 2'h0 && cfg_rdata[7:2] != 6'h00)
        else $error("capability pointer not a valid dword offset");

    // ========================================
    // checks: read path
    a_ack_follows_sel: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> cfg_ack == $past(cfg_sel))
        else $error("acknowledge does not follow select");
    a_other_read_zero: assert property (@(posedge mclk) disable iff (rst)
        rd_req && !hit_cmd && !hit_cap |=> cfg_rdata == 32'h00000000)
        else $error("unmapped read returned data");
endmodule // pcs_config_regs

// >>> bench/pcs_host_model.sv
// Purpose: host side issuing configuration cycles
// Assumes: one access per taken edge, answer one cycle later
// Notes: released address and data carry the inverse of the last value
`timescale 1ns/1ps
module pcs_host_model (
    input wire logic mclk,
    output logic cfg_sel,
    output logic cfg_wr,
    output logic [7:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_ack
);
    initial
    begin
        cfg_sel = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end
    // ========================================
    // one access, answer taken at the next edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
        input logic [31:0] d, output logic [31:0] q, output logic k);
        @(posedge mclk);
        #1;
        {cfg_sel, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, w, a, b, d};
        @(posedge mclk);
        #1;
        {cfg_sel, cfg_addr, cfg_wdata} = {1'b0, ~a, ~d};
        q = cfg_rdata;
        k = cfg_ack;
    endtask
endmodule // pcs_host_model

// >>> bench/pcs_config_regs_tb.sv
// Purpose: self-checking bench for the command enables and status word
// Assumes: host model issues the configuration cycles
// Notes: random writes and hits from a fixed seed
`timescale 1ns/1ps
module pcs_config_regs_tb;
    logic mclk, rst, mem_hit, io_hit, mem_claim, io_claim, cfg_sel, cfg_wr, cfg_ack, k;
    logic [7:0] cfg_addr, a;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, q, d;
    logic [5:0] ev, flags;
    logic [1:0] en;
    int miscompares = 0, samples_checked = 0, cyc = 0;
    pcs_config_regs i_pcs_config_regs (.mclk, .rst, .cfg_sel, .cfg_wr, .cfg_addr, .cfg_be,
        .cfg_wdata, .cfg_rdata, .cfg_ack, .mem_hit, .io_hit, .mem_claim, .io_claim,
        .ev_parity_err(ev[5]), .ev_serr(ev[4]), .ev_master_abort(ev[3]),
        .ev_target_abort_rx(ev[2]), .ev_target_abort_tx(ev[1]), .ev_master_parity(ev[0]));
    pcs_host_model i_pcs_host_model (.mclk, .cfg_sel, .cfg_wr, .cfg_addr, .cfg_be,
        .cfg_wdata, .cfg_rdata, .cfg_ack);
    function automatic logic [15:0] sts(input logic [5:0] f);
        return {f[5:1], pcs_pkg::SEL_TIMING_MEDIUM, f[0], 8'h10};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] ra, input logic [31:0] e);
        i_pcs_host_model.xfer(1'b0, ra, 4'hF, $urandom, q, k);
        chk("cfg_ack", 32'h1, {31'h0, k});
        chk("cfg_rdata", e, q);
    endtask
    task automatic hits();
        @(posedge mclk);
        #1;
        {mem_hit, io_hit} = 2'($urandom);
        #1;
        chk("mem_claim", {31'h0, mem_hit & en[1]}, {31'h0, mem_claim});
        chk("io_claim", {31'h0, io_hit & en[0]}, {31'h0, io_claim});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            miscompares++;
            conclude();
        end
    end
    // ========================================
    // main sequence
    initial
    begin
        {rst, mem_hit, io_hit, ev, flags, en} = {3'b100, 14'h0};
        q = $urandom(32'hF240);
        repeat (16) @(posedge mclk);
        #1 rst = 1'b0;
        rd(8'h04, {sts(6'h0), 16'h0});
        rd(8'h34, {24'h0, pcs_pkg::CAP_PTR_VALUE});
        rd(8'h08, 32'h0);
        for (int i = 0; i < 16; i++)
        begin
            @(posedge mclk);
            #1;
            d = $urandom;
            a = (i % 4 == 3) ? 8'h08 : 8'h04;
            ev = (i > 5 && i < 12) ? 6'h01 << (i - 6) : 6'h0;
            i_pcs_host_model.xfer(1'b1, a, (i < 4) ? 4'h1 : d[7:4], d, q, k);
            flags = flags | ev;
            ev = 6'h0;
            if (a == 8'h04 && (i < 4 || d[4]))
                en = d[1:0];
            rd(8'h04, {sts(flags), 14'h0, en});
            repeat (2) hits();
        end
        @(posedge mclk);
        #1 rst = 1'b1;
        @(posedge mclk);
        #1 rst = 1'b0;
        {en, flags} = 8'h0;
        rd(8'h04, {sts(6'h0), 16'h0});
        repeat (3) hits();
        conclude();
    end
endmodule // pcs_config_regs_tb
